// ---- hdl/uad_top.sv ----
/*
 uad_top: attach/detach control of a full-speed usb peripheral port,
 with an ahb-lite register slave, pin mapping and one interrupt.
 assumes: single ahb-lite master, one slave; serial engine signals
 (core_*) on hclk; general purpose pins asynchronous.
//
*/
// Contract
// RULE_01 - peripheral only, full speed, never bus master
// RULE_02 - pull D+ up once ready to enumerate
// RULE_03 - choose internal or pin-driven pull-up
// RULE_04 - self-powered: no pull-up without bus supply
// RULE_05 - supply sense pin chosen by setting
// RULE_06 - detach and wake pins chosen by setting
// RULE_07 - detach high: data lines float, pull-up off
// RULE_08 - detach low: reconnect, await enumeration
// RULE_09 - wake output high only during detach
// RULE_10 - no in-band wake while detached
// RULE_11 - bus-powered suspend keeps radio off
// RULE_12 - descriptor power from setting, 300 mA default
// RULE_13 - endpoint set selectable by setting
// RULE_14 - pull-up is AND of ready, supply, no detach; code applies the supply term only when self-powered
`timescale 1ns/1ps
module uad_top #(
   parameter int unsigned NPIN = uad_pkg::GPIO_N
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // general purpose pins
   input wire logic [NPIN-1:0] gpio_in,
   output logic [NPIN-1:0] gpio_out,
   output logic [NPIN-1:0] gpio_oe_n,
   // serial engine side
   input wire logic core_dp,
   input wire logic core_dn,
   input wire logic core_oe,
   input wire logic core_remote_wake,
   input wire logic core_suspend,
   output logic usb_remote_wake,
   output logic ep_set,
   output logic [7:0] max_power,
   // usb pads
   output logic usb_dp_out,
   output logic usb_dn_out,
   output logic usb_dp_oe_n,
   output logic usb_dn_oe_n,
   output logic usb_pullup_int,
   // system
   output logic radio_en,
   output logic irq
);
   import uad_pkg::*;

   initial begin
      if (NPIN < 4 || NPIN > 2**PIN_W) begin
         $error("uad_top: NPIN must lie in 4..32");
      end
   end

   uad_ctl_if ctl ();

   logic [NPIN-1:0] pin_s;
   logic [4:0] ctrl_reg;
   logic [PIN_W-1:0] pu_pin_reg;
   logic [PIN_W-1:0] sense_pin_reg;
   logic [PIN_W-1:0] det_pin_reg;
   logic [PIN_W-1:0] wake_pin_reg;
   logic [7:0] power_reg;
   logic [EV_N-1:0] stat_reg;
   logic [EV_N-1:0] stat_next;
   logic [EV_N-1:0] mask_reg;
   logic [EV_N-1:0] ev;
   logic supply_prev_reg;
   logic susp_prev_reg;
   logic wr_pend_reg;
   logic rd_wait_reg;
   logic [7:0] addr_reg;
   logic addr_ok;
   logic [31:0] rd_mux;
   logic wake_next;
   logic ext_pu;
   logic self_pw;

   // general purpose pin inputs
   uad_pin_sync #(
      .N(NPIN)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(gpio_in),
      .pin_sync(pin_s)
   );

   uad_attach_fsm u_fsm (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctl(ctl)
   );

   // out-of-range pin numbers read as low
   function automatic logic pick(input logic [NPIN-1:0] v,
      input logic [PIN_W-1:0] p);
      logic r;
      r = 1'b0;
      for (int k = 0; k < NPIN; k++) begin
         if (p == PIN_W'(k)) r = v[k];
      end
      return r;
   endfunction

   assign ext_pu = ctrl_reg[CTRL_EXTPU];
   assign self_pw = ctrl_reg[CTRL_SELF];
   assign ctl.enum_ready = ctrl_reg[CTRL_READY];
   assign ctl.self_powered = self_pw;
   assign ctl.supply_ok = pick(pin_s, sense_pin_reg); // RULE_05
   assign ctl.detach_req = pick(pin_s, det_pin_reg); // RULE_06

   // ahb-lite: writes with no wait, reads with one wait state
   assign addr_ok = hsel & htrans[1] & hready;
   assign hreadyout = ~rd_wait_reg;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_ok & hwrite;
         rd_wait_reg <= addr_ok & ~hwrite;
         if (addr_ok) addr_reg <= haddr[7:0];
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (addr_reg)
         OFF_CTRL: rd_mux = {27'h0, ctrl_reg};
         OFF_PINS: begin
            rd_mux[PINS_PU +: PIN_W] = pu_pin_reg;
            rd_mux[PINS_SENSE +: PIN_W] = sense_pin_reg;
            rd_mux[PINS_DET +: PIN_W] = det_pin_reg;
            rd_mux[PINS_WAKE +: PIN_W] = wake_pin_reg;
         end
         OFF_POWER: rd_mux = {24'h0, power_reg};
         OFF_STATUS: rd_mux = {25'h0, ctl.state, ctl.pullup_en,
            ctl.detached, ctl.supply_ok, ctl.detach_req, core_suspend};
         OFF_INT_STAT: rd_mux = {28'h0, stat_reg};
         OFF_INT_MASK: rd_mux = {28'h0, mask_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data sampled after any preceding write has landed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hrdata <= 32'h0000_0000;
      else if (rd_wait_reg) hrdata <= rd_mux;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RST; // RULE_03
      end else if (wr_pend_reg && addr_reg == OFF_CTRL) begin
         ctrl_reg <= hwdata[4:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pu_pin_reg <= PU_PIN_RST;
         sense_pin_reg <= SENSE_PIN_RST;
         det_pin_reg <= DET_PIN_RST;
         wake_pin_reg <= WAKE_PIN_RST;
      end else if (wr_pend_reg && addr_reg == OFF_PINS) begin
         pu_pin_reg <= hwdata[PINS_PU +: PIN_W];
         sense_pin_reg <= hwdata[PINS_SENSE +: PIN_W];
         det_pin_reg <= hwdata[PINS_DET +: PIN_W];
         wake_pin_reg <= hwdata[PINS_WAKE +: PIN_W];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) power_reg <= POWER_RST; // RULE_12
      else if (wr_pend_reg && addr_reg == OFF_POWER) begin
         power_reg <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) mask_reg <= '0;
      else if (wr_pend_reg && addr_reg == OFF_INT_MASK) begin
         mask_reg <= hwdata[EV_N-1:0];
      end
   end

   // events; a set in the clearing cycle survives the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         supply_prev_reg <= 1'b0;
         susp_prev_reg <= 1'b0;
      end else begin
         supply_prev_reg <= ctl.supply_ok;
         susp_prev_reg <= core_suspend;
      end
   end

   always_comb begin
      ev = '0;
      ev[EV_ATTACH] = ctl.ev_attach;
      ev[EV_DETACH] = ctl.ev_detach;
      ev[EV_SUPPLY] = ctl.supply_ok ^ supply_prev_reg;
      ev[EV_SUSPEND] = core_suspend & ~susp_prev_reg;
      stat_next = stat_reg;
      if (wr_pend_reg && addr_reg == OFF_INT_STAT) begin
         stat_next = stat_reg & ~hwdata[EV_N-1:0];
      end
      stat_next = stat_next | ev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) stat_reg <= '0;
      else stat_reg <= stat_next;
   end

   assign irq = |(stat_reg & mask_reg);

   // data lines: only ever answer the host, float while detached
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         usb_dp_out <= 1'b0;
         usb_dn_out <= 1'b0;
         usb_dp_oe_n <= 1'b1;
         usb_dn_oe_n <= 1'b1;
      end else begin
         usb_dp_out <= core_dp; // RULE_01
         usb_dn_out <= core_dn;
         usb_dp_oe_n <= ~(core_oe & ~ctl.detached); // RULE_07
         usb_dn_oe_n <= ~(core_oe & ~ctl.detached);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) usb_pullup_int <= 1'b0;
      else usb_pullup_int <= ctl.pullup_en & ~ext_pu; // RULE_03
   end

   // in-band wake would be lost on a floating bus
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) usb_remote_wake <= 1'b0;
      else usb_remote_wake <= core_remote_wake & ~ctl.detached & // RULE_10
         (ctl.state == UAD_ST_ATTACHED);
   end

   // bus-powered suspend leaves no budget for the radio
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) radio_en <= 1'b1;
      else radio_en <= ~(core_suspend & ~self_pw); // RULE_11
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ep_set <= 1'b0;
         max_power <= POWER_RST;
      end else begin
         ep_set <= ctrl_reg[CTRL_EPSET]; // RULE_13
         max_power <= power_reg; // RULE_12
      end
   end

   assign wake_next = ctrl_reg[CTRL_WAKE] & ctl.detach_req; // RULE_09

   // pin drivers; pull-up pin floats when off, wake pin driven always
   genvar i;
   generate
      for (i = 0; i < NPIN; i++) begin : g_pin
         localparam logic [PIN_W-1:0] IDX = PIN_W'(i);
         logic pu_here;
         logic wk_here;
         assign pu_here = ext_pu & (pu_pin_reg == IDX);
         assign wk_here = (wake_pin_reg == IDX);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               gpio_out[i] <= 1'b0;
               gpio_oe_n[i] <= 1'b1;
            end else begin
               gpio_out[i] <= (pu_here & ctl.pullup_en) | // RULE_03
                  (wk_here & wake_next); // RULE_06
               gpio_oe_n[i] <= ~((pu_here & ctl.pullup_en) | wk_here);
            end
         end
      end
   endgenerate

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_detach_float: assert property (ctl.detach_req |-> ##2 // RULE_07
      usb_dp_oe_n && usb_dn_oe_n && !usb_pullup_int)
      else $error("data lines or pull-up active during detach");
   a_wake_detach: assert property ( // RULE_09
      pick(gpio_out, wake_pin_reg) && !ext_pu |-> $past(ctl.detach_req))
      else $error("wake pin high without detach request");
   a_no_inband: assert property ( // RULE_10
      usb_remote_wake |-> !$past(ctl.detached))
      else $error("in-band wake sent while detached");
   a_radio_off: assert property ( // RULE_11
      core_suspend && !self_pw |=> !radio_en)
      else $error("radio on in bus-powered suspend");
   a_ext_pullup: assert property ( // RULE_03
      ext_pu && $stable(ext_pu) |=> !usb_pullup_int)
      else $error("internal pull-up used in external mode");
   a_read_wait: assert property (addr_ok && !hwrite |=> // RULE_01
      !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait state");
   a_stat_set_wins: assert property (ctl.ev_detach |=> // RULE_07
      stat_reg[EV_DETACH])
      else $error("detach event lost");
endmodule

// ---- hdl/uad_pkg.sv ----
/*
 uad_pkg: register map, field positions, reset values, events and
 attach states of the attach/detach control block.
 assumes: every design file imports it whole.
*/
package uad_pkg;
   // core clock and full-speed signalling rate
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned USB_FS_BPS = 12_000_000;
   localparam int unsigned PIN_W = 5;
   localparam int unsigned GPIO_N = 32;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PINS = 8'h04;
   localparam logic [7:0] OFF_POWER = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_INT_STAT = 8'h10;
   localparam logic [7:0] OFF_INT_MASK = 8'h14;
   // control bits
   localparam int unsigned CTRL_READY = 0;
   localparam int unsigned CTRL_SELF = 1;
   localparam int unsigned CTRL_EXTPU = 2;
   localparam int unsigned CTRL_EPSET = 3;
   localparam int unsigned CTRL_WAKE = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // pin number fields, one per byte
   localparam int unsigned PINS_PU = 0;
   localparam int unsigned PINS_SENSE = 8;
   localparam int unsigned PINS_DET = 16;
   localparam int unsigned PINS_WAKE = 24;
   localparam logic [PIN_W-1:0] PU_PIN_RST = 5'h00;
   localparam logic [PIN_W-1:0] SENSE_PIN_RST = 5'h01;
   localparam logic [PIN_W-1:0] DET_PIN_RST = 5'h02;
   localparam logic [PIN_W-1:0] WAKE_PIN_RST = 5'h03;
   // descriptor power in 2 mA units: 300 mA
   localparam logic [7:0] POWER_RST = 8'h96;
   // sticky events
   localparam int unsigned EV_N = 4;
   localparam int unsigned EV_ATTACH = 0;
   localparam int unsigned EV_DETACH = 1;
   localparam int unsigned EV_SUPPLY = 2;
   localparam int unsigned EV_SUSPEND = 3;
   typedef enum logic [1:0] {
      UAD_ST_IDLE,
      UAD_ST_ATTACHED,
      UAD_ST_DETACHED
   } uad_state_e;
endpackage

// ---- hdl/uad_ctl_if.sv ----
/*
 uad_ctl_if: bundle between the top and the attach state machine.
 assumes: one clock domain, all signals on hclk.
*/
`timescale 1ns/1ps
interface uad_ctl_if;
   import uad_pkg::*;
   logic enum_ready;
   logic self_powered;
   logic supply_ok;
   logic detach_req;
   logic pullup_en;
   logic detached;
   uad_state_e state;
   logic ev_attach;
   logic ev_detach;
   modport top (
      output enum_ready, self_powered, supply_ok, detach_req,
      input pullup_en, detached, state, ev_attach, ev_detach
   );
   modport fsm (
      input enum_ready, self_powered, supply_ok, detach_req,
      output pullup_en, detached, state, ev_attach, ev_detach
   );
endinterface

// ---- hdl/uad_pin_sync.sv ----
/*
 uad_pin_sync: two flip-flop synchroniser for every general purpose pin.
 assumes: pins are asynchronous to hclk.
*/
`timescale 1ns/1ps
module uad_pin_sync #(
   parameter int unsigned N = 32
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // pins
   input wire logic [N-1:0] pin_in,
   output logic [N-1:0] pin_sync
);
   import uad_pkg::*;
   initial begin
      if (N < 1) $error("uad_pin_sync: N must be at least 1");
   end
   logic [N-1:0] meta_reg;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         // first stage feeds the second stage only
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               meta_reg[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
            end else begin
               meta_reg[i] <= pin_in[i];
               pin_sync[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
endmodule

// ---- hdl/uad_attach_fsm.sv ----
/*
 uad_attach_fsm: attach state and registered pull-up enable.
 assumes: inputs already synchronised to hclk by the top.
*/
`timescale 1ns/1ps
module uad_attach_fsm (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control bundle
   uad_ctl_if.fsm ctl
);
   import uad_pkg::*;
   uad_state_e state_reg;
   uad_state_e state_next;
   logic pullup_reg;
   logic pullup_next;
   logic detached_reg;

   assign pullup_next = ctl.enum_ready & ~ctl.detach_req & // RULE_14
      (ctl.supply_ok | ~ctl.self_powered); // RULE_04

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         UAD_ST_IDLE: begin
            if (ctl.detach_req) state_next = UAD_ST_DETACHED;
            else if (pullup_next) state_next = UAD_ST_ATTACHED;
         end
         UAD_ST_ATTACHED: begin
            if (ctl.detach_req) state_next = UAD_ST_DETACHED;
            else if (!pullup_next) state_next = UAD_ST_IDLE;
         end
         UAD_ST_DETACHED: begin
            // back on the bus as soon as the request drops
            if (!ctl.detach_req) begin // RULE_08
               state_next = pullup_next ? UAD_ST_ATTACHED : UAD_ST_IDLE;
            end
         end
         default: state_next = UAD_ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) state_reg <= UAD_ST_IDLE;
      else state_reg <= state_next;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pullup_reg <= 1'b0;
      else pullup_reg <= pullup_next; // RULE_02
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) detached_reg <= 1'b0;
      else detached_reg <= ctl.detach_req; // RULE_07
   end

   assign ctl.ev_attach = (state_next == UAD_ST_ATTACHED) &&
      (state_reg != UAD_ST_ATTACHED);
   assign ctl.ev_detach = (state_next == UAD_ST_DETACHED) &&
      (state_reg != UAD_ST_DETACHED);
   assign ctl.pullup_en = pullup_reg;
   assign ctl.detached = detached_reg;
   assign ctl.state = state_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_release;
      ctl.detach_req ##1 !ctl.detach_req && ctl.enum_ready &&
         (ctl.supply_ok || !ctl.self_powered);
   endsequence

   a_pullup_gate: assert property (pullup_reg |-> // RULE_14
      $past(ctl.enum_ready) && !$past(ctl.detach_req))
      else $error("pull-up on without ready or during detach");
   a_supply_gate: assert property ( // RULE_04
      ctl.self_powered && !ctl.supply_ok |=> !pullup_reg)
      else $error("pull-up on while bus supply is off");
   a_reattach_seq: assert property ( // RULE_08
      s_release |=> state_reg == UAD_ST_ATTACHED && pullup_reg)
      else $error("no reattach after detach release");
endmodule

// ---- sim/uad_host_model.sv ----
/*
 uad_host_model: host side of the out-of-band lines; drives the bus
 supply sense and detach pins, answers the wake pin after a delay.
 assumes: hclk domain; the block resynchronises every pin it reads.
*/
`timescale 1ns/1ps
module uad_host_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bench commands
   input wire logic supply_on,
   input wire logic detach_cmd,
   input wire logic [7:0] wake_lat,
   // device pins
   input wire logic pullup_seen,
   input wire logic wake_seen,
   output logic supply_pin,
   output logic detach_pin,
   output logic host_attached
);
   logic [7:0] wake_cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         supply_pin <= 1'b0;
         host_attached <= 1'b0;
      end else begin
         supply_pin <= supply_on;
         // an unpowered port never sees a device
         host_attached <= pullup_seen & supply_pin;
      end
   end
   // detach held until wake has stood wake_lat+1 cycles: slow host
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         detach_pin <= 1'b0;
         wake_cnt <= 8'h00;
      end else if (detach_cmd) begin
         detach_pin <= 1'b1;
         wake_cnt <= 8'h00;
      end else if (detach_pin && wake_seen) begin
         wake_cnt <= wake_cnt + 8'h01;
         if (wake_cnt == wake_lat)
            detach_pin <= 1'b0;
      end
   end
endmodule

// ---- sim/uad_top_tb_top.sv ----
/*
 uad_top_tb_top: self-checking bench of the attach/detach block with an
 ahb-lite master, a host model on the pins and serial engine stimulus.
 assumes: the block's hreadyout is the bus hready; one 200 MHz clock.
*/
`timescale 1ns/1ps
module uad_top_tb_top;
   import uad_pkg::*;
   localparam int PU = 5;
   localparam int WK = 11;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] gpio_in, gpio_out, gpio_oe_n;
   logic core_dp, core_dn, core_oe, core_remote_wake, core_suspend;
   logic usb_remote_wake, ep_set, usb_dp_out, usb_dn_out;
   logic usb_dp_oe_n, usb_dn_oe_n, usb_pullup_int, radio_en, irq;
   logic [7:0] max_power, wake_lat;
   logic supply_on, detach_cmd, supply_pin, detach_pin, host_attached;
   logic pins_new, pull_seen, wake_seen;
   int fail_count, checked, n;

   uad_top #(.NPIN(32)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
      .core_dp(core_dp), .core_dn(core_dn), .core_oe(core_oe),
      .core_remote_wake(core_remote_wake), .core_suspend(core_suspend),
      .usb_remote_wake(usb_remote_wake), .ep_set(ep_set),
      .max_power(max_power), .usb_dp_out(usb_dp_out),
      .usb_dn_out(usb_dn_out), .usb_dp_oe_n(usb_dp_oe_n),
      .usb_dn_oe_n(usb_dn_oe_n), .usb_pullup_int(usb_pullup_int),
      .radio_en(radio_en), .irq(irq));

   uad_host_model i_host (.hclk(hclk), .hresetn(hresetn),
      .supply_on(supply_on), .detach_cmd(detach_cmd),
      .wake_lat(wake_lat), .pullup_seen(pull_seen),
      .wake_seen(wake_seen), .supply_pin(supply_pin),
      .detach_pin(detach_pin), .host_attached(host_attached));

   // pull-up seen either inside or through the chosen pin
   assign pull_seen = usb_pullup_int | (gpio_out[PU] & ~gpio_oe_n[PU]);
   assign wake_seen = gpio_out[WK] & ~gpio_oe_n[WK];
   // pin map follows the PINS value the bench wrote
   always_comb begin
      gpio_in = '0;
      gpio_in[pins_new ? 7 : 1] = supply_pin;
      gpio_in[pins_new ? 9 : 2] = detach_pin;
   end

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // hreadyout read at the falling edge is what the next rise samples
   task automatic wait_rdy;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 20) begin
         n++;
         @(negedge hclk);
      end
      if (n == 20) begin
         fail_count++;
         end_sim;
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'b010;
      wait_rdy;
      @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
      chk(hresp, 1'b0);
      @(posedge hclk);
      // read data taken at the edge that samples hready high
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic settle;
      repeat (6) @(posedge hclk);
      @(negedge hclk);
   endtask

   initial begin
      {hresetn, hsel, hwrite, core_dp, core_dn, core_oe} = '0;
      {core_remote_wake, core_suspend, detach_cmd, pins_new} = '0;
      {haddr, hwdata, htrans, hsize} = '0;
      supply_on = 1'b1;
      wake_lat = 8'd60;
      fail_count = 0;
      checked = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(OFF_CTRL, {27'h0, CTRL_RST});
      rdc(OFF_PINS, 32'h03020100);
      rdc(OFF_POWER, {24'h0, POWER_RST});
      rdc(8'h18, 32'h0);
      chk(max_power, 8'h96);
      chk(ep_set, 1'b0);
      chk(usb_pullup_int, 1'b0);
      wr(OFF_PINS, 32'h0b090705);
      pins_new <= 1'b1;
      wr(OFF_INT_MASK, 32'hf);
      wr(OFF_INT_STAT, 32'hf);
      wr(OFF_CTRL, 32'h1);
      core_dp <= 1'b1;
      core_oe <= 1'b1;
      settle;
      chk(usb_pullup_int, 1'b1);
      chk(host_attached, 1'b1);
      chk(usb_dp_out, 1'b1);
      chk(usb_dn_out, 1'b0);
      chk(usb_dp_oe_n, 1'b0);
      rdc(OFF_INT_STAT, 32'h1 << EV_ATTACH);
      chk(irq, 1'b1);
      wr(OFF_INT_STAT, 32'h1);
      settle;
      chk(irq, 1'b0);
      // external pull-up on pin PU, endpoint set and power value
      wr(OFF_CTRL, 32'h0d);
      wr(OFF_POWER, 32'h32);
      settle;
      chk(usb_pullup_int, 1'b0);
      chk({gpio_oe_n[PU], gpio_out[PU]}, 2'b01);
      chk(ep_set, 1'b1);
      chk(max_power, 8'h32);
      // self powered: no pull-up until the sense pin reports supply
      @(posedge hclk);
      supply_on <= 1'b0;
      wr(OFF_CTRL, 32'h3);
      settle;
      chk(usb_pullup_int, 1'b0);
      wr(OFF_INT_STAT, 32'hf);
      @(posedge hclk);
      supply_on <= 1'b1;
      settle;
      chk(usb_pullup_int, 1'b1);
      rdc(OFF_INT_STAT, 32'h5);
      rdc(OFF_STATUS, 32'h34);
      // suspend stops the radio only when bus powered
      @(posedge hclk);
      core_suspend <= 1'b1;
      settle;
      chk(radio_en, 1'b1);
      wr(OFF_CTRL, 32'h1);
      settle;
      chk(radio_en, 1'b0);
      @(posedge hclk);
      core_suspend <= 1'b0;
      settle;
      chk(radio_en, 1'b1);
      // detach with wake requested; the host releases after the wake
      wr(OFF_CTRL, 32'h11);
      wr(OFF_INT_STAT, 32'hf);
      @(posedge hclk);
      core_remote_wake <= 1'b1;
      detach_cmd <= 1'b1;
      @(posedge hclk);
      detach_cmd <= 1'b0;
      // clear lands in the cycle the detach event rises: set must win
      wr(OFF_INT_STAT, 32'hf);
      settle;
      chk({usb_dp_oe_n, usb_dn_oe_n}, 2'b11);
      chk(usb_pullup_int, 1'b0);
      chk(usb_remote_wake, 1'b0);
      chk(wake_seen, 1'b1);
      chk(irq, 1'b1);
      rdc(OFF_INT_STAT, 32'h1 << EV_DETACH);
      wr(OFF_INT_MASK, 32'h0);
      settle;
      chk(irq, 1'b0);
      n = 0;
      while (host_attached !== 1'b1 && n < 300) begin
         n++;
         @(posedge hclk);
      end
      if (n == 300) begin
         fail_count++;
         end_sim;
      end
      settle;
      chk(wake_seen, 1'b0);
      chk({usb_dp_oe_n, usb_pullup_int}, 2'b01);
      chk(usb_remote_wake, 1'b1);
      rdc(OFF_INT_STAT, 32'h3);
      end_sim;
   end
endmodule
